// file: scsm_pkg.sv
/*
  constants shared by the system clock select and multiplier block:
  register addresses, field positions, reset values, encodings, counts.
  assumes an 8-bit internal register bus and a 20 MHz control clock.
*/
package scsm_pkg;

  // ************************************************************
  // register addresses on the internal register bus
  // ************************************************************
  localparam logic [7:0] SCSM_ADDR_SYSTEM_CLOCK_SELECT = 8'hA9;
  localparam logic [7:0] SCSM_ADDR_CLOCK_MULTIPLIER_CONTROL = 8'hAB;
  localparam logic [7:0] SCSM_ADDR_EXTERNAL_OSCILLATOR_CONTROL = 8'hB1;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] SCSM_RST_SYSTEM_CLOCK_SELECT = 8'h00;
  localparam logic [7:0] SCSM_RST_CLOCK_MULTIPLIER_CONTROL = 8'h00;
  localparam logic [7:0] SCSM_RST_EXTERNAL_OSCILLATOR_CONTROL = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SCSM_XCN_VALID_BIT = 7;
  localparam int SCSM_XCN_MODE_LSB = 4;
  localparam int SCSM_XCN_DRIVE_LSB = 0;
  localparam int SCSM_MUL_ENABLE_BIT = 7;
  localparam int SCSM_MUL_INIT_BIT = 6;
  localparam int SCSM_MUL_LOCKED_BIT = 5;
  localparam int SCSM_MUL_SCALE_LSB = 2;
  localparam int SCSM_MUL_SOURCE_LSB = 0;
  localparam int SCSM_SEL_PIN_DIV_LSB = 4;
  localparam int SCSM_SEL_SOURCE_LSB = 0;

  // ************************************************************
  // encodings
  // ************************************************************
  localparam logic [2:0] SCSM_XMODE_CMOS = 3'h2;
  localparam logic [2:0] SCSM_XMODE_CMOS_HALF = 3'h3;
  localparam logic [2:0] SCSM_XMODE_RC = 3'h4;
  localparam logic [2:0] SCSM_XMODE_CAP = 3'h5;
  localparam logic [2:0] SCSM_XMODE_XTAL = 3'h6;
  localparam logic [2:0] SCSM_XMODE_XTAL_HALF = 3'h7;
  localparam logic [1:0] SCSM_MSRC_INT_HALF = 2'h0;
  localparam logic [1:0] SCSM_MSRC_EXT = 2'h1;
  localparam logic [1:0] SCSM_MSRC_EXT_HALF = 2'h2;
  localparam logic [1:0] SCSM_MSRC_INT = 2'h3;
  localparam logic [1:0] SCSM_CLK_INT = 2'h0;
  localparam logic [1:0] SCSM_CLK_EXT = 2'h1;
  localparam logic [1:0] SCSM_CLK_MULT = 2'h2;
  localparam logic [1:0] SCSM_CLK_RTC = 2'h3;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int SCSM_MCLK_HZ = 20000000;
  localparam int SCSM_MULT_LOCK_NS = 3200;
  localparam int SCSM_MULT_LOCK_CYCLES =
    (SCSM_MULT_LOCK_NS * (SCSM_MCLK_HZ / 1000000) + 999) / 1000;
  localparam int SCSM_XTAL_SETTLE_EDGES = 1024;
  localparam int SCSM_MULT_TICKS = 16;
  localparam logic [15:0] SCSM_MULT_FAST_SPACING = 16'h0004;

endpackage

// file: scsm_mult_core.sv
/*
  clock multiplier core: sixteen ticks per input period, output toggled
  every k ticks, giving four times the input scaled by 2/k.
  assumes a one-cycle rising-edge pulse of the chosen input clock.
*/
module scsm_mult_core
  import scsm_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] scale_i,
  input wire logic src_rise_i,
  // output clock level
  output logic mult_clk_o
);

  logic [15:0] period_cnt_r;
  logic [15:0] period_r;
  logic [15:0] gap_r;
  logic [4:0] ticks_left_r;
  logic [2:0] tog_cnt_r;
  logic [15:0] spacing;
  logic tick;

  // division count k for a factor of 2/k
  function automatic logic [2:0] scale_to_k(input logic [2:0] code);
    scale_to_k = (code < 3'h2) ? 3'h2 : code;
  endfunction

  // ************************************************************
  // input period measurement
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_i) begin
      period_cnt_r <= 16'h0000;
      period_r <= 16'h0000;
    end else if (src_rise_i) begin
      period_r <= period_cnt_r;
      period_cnt_r <= 16'h0001;
    end else if (period_cnt_r != 16'hFFFF) begin
      period_cnt_r <= period_cnt_r + 16'h0001;
    end
  end

  // tick spacing, clamped so a slow input gives fast bursts
  always_comb begin
    spacing = period_r >> 4;
    if (spacing > SCSM_MULT_FAST_SPACING) begin
      spacing = SCSM_MULT_FAST_SPACING;
    end
    if (spacing == 16'h0000) begin
      spacing = 16'h0001;
    end
  end

  // ************************************************************
  // tick burst after each input rising edge
  // ************************************************************
  assign tick = (ticks_left_r != 5'h00) && (gap_r == 16'h0000);

  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_i) begin
      ticks_left_r <= 5'h00;
      gap_r <= 16'h0000;
    end else if (src_rise_i) begin
      ticks_left_r <= 5'(SCSM_MULT_TICKS);
      gap_r <= 16'h0000;
    end else if (ticks_left_r != 5'h00) begin
      if (gap_r == 16'h0000) begin
        ticks_left_r <= ticks_left_r - 5'h01;
        gap_r <= spacing - 16'h0001;
      end else begin
        gap_r <= gap_r - 16'h0001;
      end
    end
  end

  // ************************************************************
  // scaled output, odd k gives uneven duty
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i || !run_i) begin
      tog_cnt_r <= 3'h0;
      mult_clk_o <= 1'b0;
    end else if (tick) begin
      if (tog_cnt_r >= scale_to_k(scale_i) - 3'h1) begin
        tog_cnt_r <= 3'h0;
        mult_clk_o <= ~mult_clk_o;
      end else begin
        tog_cnt_r <= tog_cnt_r + 3'h1;
      end
    end
  end

endmodule

// file: scsm_clock_control.sv
/*
  system clock select and multiplier control: three registers on the
  internal register bus, external oscillator mode decode and crystal
  valid flag, clock multiplier control and lock, glitch-free system
  clock selector, pin copy divider and timer copy of the external clock.
  assumes oscillator levels arrive asynchronously on pins and are
  oversampled by the 20 MHz control clock; the analog parts are outside.
*/
// Overview of operation
// - top bit of external control reads one once the crystal runs stably.
// - mode bits 6-4 select off, CMOS, CMOS halved, RC, capacitor, crystal, halved crystal.
// - bit 3 of external control is reserved, reads zero, software writes zero.
// - bits 2-0 drive range go out unchanged to the oscillator circuit.
// - multiplier output is four times its input, then scaled.
// - a slow input gives fast pulse bursts, then waits for next edge.
// - multiplier enable bit 7 turns the multiplier off or on.
// - initialise written one after enabling starts lock acquisition.
// - read-only ready bit 5 shows one once the multiplier has locked.
// - scale bits 4-2 give factors 1, 2/3, 1/2, 2/5, 1/3, 2/7.
// - odd scale factors may produce an uneven duty cycle.
// - source bits 1-0 pick internal halved, external, external halved, internal.
// - select bits 1-0 route internal, external, multiplier or RTC clock.
// - external clock stays available to timers whatever drives the system.
// - source may change while running; software picks only settled sources.
// - pin divide bits 5-4 give system clock divided by 1, 2, 4, 8.
// - select bits 7-6, 3 and 2 read zero and ignore writes.
// - internal oscillator is usable immediately, no settling wait.
// - internal divide code 111 divides by 1, down to 001 by 64.
module scsm_clock_control
  import scsm_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // internal register bus
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // oscillator levels from the analog side
  input wire logic int_osc_i,
  input wire logic ext_osc_i,
  input wire logic rtc_osc_i,
  input wire logic [2:0] internal_divide_select_i,
  // controls to the external oscillator circuit
  output logic [2:0] ext_osc_mode_o,
  output logic [2:0] ext_osc_drive_range_o,
  // clock outputs
  output logic system_clock_o,
  output logic system_clock_pin_o,
  output logic ext_timer_clock_o,
  output logic mult_clock_o
);

  typedef enum logic [1:0] {
    SCSM_SW_RUN,
    SCSM_SW_OLD_LOW,
    SCSM_SW_NEW_LOW
  } scsm_switch_e;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [2:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r, pin_prev_r, pin_rise;
  logic [2:0] ext_osc_mode_r, ext_osc_drive_range_r, mult_scale_r, pin_div_cnt_r;
  logic [1:0] mult_source_r, system_clock_pin_divide_r, system_clock_source_r, sw_cur_r, timer_div_cnt_r;
  logic mult_enable_r, mult_initialise_r, crystal_valid_flag_r, ext_half_r, ext_clk, ext_clk_prev_r;
  logic [10:0] xtal_edge_cnt_r;
  logic [5:0] int_div_cnt_r;
  logic [7:0] lock_cnt_r;
  logic [3:0] candidate;
  logic int_div_clk, mult_locked_r, mult_locking_r, mult_src_rise, mult_int_half_r;
  logic system_clock_r, system_clock_prev_r, xtal_mode, wr_sel, wr_mul, wr_xcn;
  scsm_switch_e sw_state_r;

  // ************************************************************
  // pin synchronisers: level taken once stages two and three agree
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
      pin_lvl_r <= 3'h0;
      pin_prev_r <= 3'h0;
    end else begin
      pin_s1_r <= {rtc_osc_i, ext_osc_i, int_osc_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r | pin_s3_r));
      pin_prev_r <= pin_lvl_r;
    end
  end

  // one-cycle rising edges: bit 0 internal, 1 external, 2 rtc
  assign pin_rise = pin_lvl_r & ~pin_prev_r;

  // ************************************************************
  // register writes
  // ************************************************************
  assign wr_sel = reg_wr_i && (reg_addr_i == SCSM_ADDR_SYSTEM_CLOCK_SELECT);
  assign wr_mul = reg_wr_i && (reg_addr_i == SCSM_ADDR_CLOCK_MULTIPLIER_CONTROL);
  assign wr_xcn = reg_wr_i && (reg_addr_i == SCSM_ADDR_EXTERNAL_OSCILLATOR_CONTROL);

  // external oscillator control, valid bit and bit 3 not stored
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ext_osc_mode_r <= SCSM_RST_EXTERNAL_OSCILLATOR_CONTROL[SCSM_XCN_MODE_LSB +: 3];
      ext_osc_drive_range_r <= SCSM_RST_EXTERNAL_OSCILLATOR_CONTROL[SCSM_XCN_DRIVE_LSB +: 3];
    end else if (wr_xcn) begin
      ext_osc_mode_r <= reg_wdata_i[SCSM_XCN_MODE_LSB +: 3];
      ext_osc_drive_range_r <= reg_wdata_i[SCSM_XCN_DRIVE_LSB +: 3];
    end
  end

  // multiplier control, ready bit not stored
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mult_enable_r <= SCSM_RST_CLOCK_MULTIPLIER_CONTROL[SCSM_MUL_ENABLE_BIT];
      mult_initialise_r <= SCSM_RST_CLOCK_MULTIPLIER_CONTROL[SCSM_MUL_INIT_BIT];
      mult_scale_r <= SCSM_RST_CLOCK_MULTIPLIER_CONTROL[SCSM_MUL_SCALE_LSB +: 3];
      mult_source_r <= SCSM_RST_CLOCK_MULTIPLIER_CONTROL[SCSM_MUL_SOURCE_LSB +: 2];
    end else if (wr_mul) begin
      mult_enable_r <= reg_wdata_i[SCSM_MUL_ENABLE_BIT];
      mult_initialise_r <= reg_wdata_i[SCSM_MUL_INIT_BIT];
      mult_scale_r <= reg_wdata_i[SCSM_MUL_SCALE_LSB +: 3];
      mult_source_r <= reg_wdata_i[SCSM_MUL_SOURCE_LSB +: 2];
    end
  end

  // clock select, bits 7-6, 3 and 2 dropped
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      system_clock_pin_divide_r <= SCSM_RST_SYSTEM_CLOCK_SELECT[SCSM_SEL_PIN_DIV_LSB +: 2];
      system_clock_source_r <= SCSM_RST_SYSTEM_CLOCK_SELECT[SCSM_SEL_SOURCE_LSB +: 2];
    end else if (wr_sel) begin
      system_clock_pin_divide_r <= reg_wdata_i[SCSM_SEL_PIN_DIV_LSB +: 2];
      system_clock_source_r <= reg_wdata_i[SCSM_SEL_SOURCE_LSB +: 2];
    end
  end

  // ************************************************************
  // register reads, data one cycle after the read strobe
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == SCSM_ADDR_EXTERNAL_OSCILLATOR_CONTROL) begin
        reg_rdata_o <= {crystal_valid_flag_r, ext_osc_mode_r, 1'b0, ext_osc_drive_range_r};
      end else if (reg_addr_i == SCSM_ADDR_CLOCK_MULTIPLIER_CONTROL) begin
        reg_rdata_o <= {mult_enable_r, mult_initialise_r, mult_locked_r, mult_scale_r,
                        mult_source_r};
      end else if (reg_addr_i == SCSM_ADDR_SYSTEM_CLOCK_SELECT) begin
        reg_rdata_o <= {2'b00, system_clock_pin_divide_r, 2'b00, system_clock_source_r};
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ************************************************************
  // external oscillator: mode decode and crystal valid
  // ************************************************************
  assign ext_osc_mode_o = ext_osc_mode_r;
  assign ext_osc_drive_range_o = ext_osc_drive_range_r;
  assign xtal_mode = (ext_osc_mode_r == SCSM_XMODE_XTAL) || (ext_osc_mode_r == SCSM_XMODE_XTAL_HALF);

  // divide-by-two stage on external rising edges
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ext_half_r <= 1'b0;
    end else if (pin_rise[1]) begin
      ext_half_r <= ~ext_half_r;
    end
  end

  // external clock as the chosen mode presents it
  always_comb begin
    case (ext_osc_mode_r)
      SCSM_XMODE_CMOS, SCSM_XMODE_RC, SCSM_XMODE_CAP, SCSM_XMODE_XTAL: ext_clk = pin_lvl_r[1];
      SCSM_XMODE_CMOS_HALF, SCSM_XMODE_XTAL_HALF: ext_clk = ext_half_r;
      default: ext_clk = 1'b0;
    endcase
  end

  // crystal counted settled after a run of edges in crystal mode
  always_ff @(posedge mclk_i) begin
    if (reset_i || !xtal_mode) begin
      xtal_edge_cnt_r <= 11'h000;
      crystal_valid_flag_r <= 1'b0;
    end else if (pin_rise[1]) begin
      if (xtal_edge_cnt_r == 11'(SCSM_XTAL_SETTLE_EDGES - 1)) begin
        crystal_valid_flag_r <= 1'b1;
      end else begin
        xtal_edge_cnt_r <= xtal_edge_cnt_r + 11'h001;
      end
    end
  end

  // ************************************************************
  // timer copy of the external clock, divided by eight
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ext_clk_prev_r <= 1'b0;
      timer_div_cnt_r <= 2'h0;
      ext_timer_clock_o <= 1'b0;
    end else begin
      ext_clk_prev_r <= ext_clk;
      if (ext_clk && !ext_clk_prev_r) begin
        timer_div_cnt_r <= timer_div_cnt_r + 2'h1;
        if (timer_div_cnt_r == 2'h3) begin
          ext_timer_clock_o <= ~ext_timer_clock_o;
        end
      end
    end
  end

  // ************************************************************
  // internal oscillator divided by a power of two
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      int_div_cnt_r <= 6'h00;
    end else if (pin_rise[0]) begin
      int_div_cnt_r <= int_div_cnt_r + 6'h01;
    end
  end

  // code 111 passes the oscillator, lower codes take higher counter bits
  always_comb begin
    case (internal_divide_select_i)
      3'h7: int_div_clk = pin_lvl_r[0];
      3'h6: int_div_clk = int_div_cnt_r[0];
      3'h5: int_div_clk = int_div_cnt_r[1];
      3'h4: int_div_clk = int_div_cnt_r[2];
      3'h3: int_div_clk = int_div_cnt_r[3];
      3'h2: int_div_clk = int_div_cnt_r[4];
      default: int_div_clk = int_div_cnt_r[5];
    endcase
  end

  // ************************************************************
  // multiplier source and halving stages
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mult_int_half_r <= 1'b0;
    end else if (pin_rise[0]) begin
      mult_int_half_r <= ~mult_int_half_r;
    end
  end

  // rising edge of the selected multiplier input
  always_comb begin
    case (mult_source_r)
      SCSM_MSRC_INT_HALF: mult_src_rise = pin_rise[0] && !mult_int_half_r;
      SCSM_MSRC_EXT: mult_src_rise = pin_rise[1];
      SCSM_MSRC_EXT_HALF: mult_src_rise = pin_rise[1] && !ext_half_r; // shares the mode halver
      default: mult_src_rise = pin_rise[0];
    endcase
  end

  // ************************************************************
  // multiplier lock sequence
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i || !mult_enable_r || (wr_mul && !reg_wdata_i[SCSM_MUL_ENABLE_BIT])) begin
      mult_locking_r <= 1'b0;
      mult_locked_r <= 1'b0;
      lock_cnt_r <= 8'h00;
    end else if (wr_mul && reg_wdata_i[SCSM_MUL_ENABLE_BIT] && reg_wdata_i[SCSM_MUL_INIT_BIT]
                 && !mult_initialise_r) begin
      mult_locking_r <= 1'b1;
      mult_locked_r <= 1'b0;
      lock_cnt_r <= 8'h00;
    end else if (mult_locking_r) begin
      if (lock_cnt_r == 8'(SCSM_MULT_LOCK_CYCLES - 1)) begin
        mult_locking_r <= 1'b0;
        mult_locked_r <= 1'b1;
      end else begin
        lock_cnt_r <= lock_cnt_r + 8'h01;
      end
    end
  end

  // multiplier runs while enabled
  scsm_mult_core u_mult (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .run_i(mult_enable_r),
    .scale_i(mult_scale_r),
    .src_rise_i(mult_src_rise),
    .mult_clk_o(mult_clock_o)
  );

  // ************************************************************
  // glitch-free system clock switch
  // ************************************************************
  assign candidate = {pin_lvl_r[2], mult_clock_o, ext_clk, int_div_clk};

  // hold old clock until low, park low, wait for new clock low
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sw_state_r <= SCSM_SW_RUN;
      sw_cur_r <= SCSM_CLK_INT;
      system_clock_r <= 1'b0;
    end else begin
      case (sw_state_r)
        SCSM_SW_RUN: begin
          system_clock_r <= candidate[sw_cur_r];
          if (system_clock_source_r != sw_cur_r) begin
            sw_state_r <= SCSM_SW_OLD_LOW;
          end
        end
        SCSM_SW_OLD_LOW: begin
          system_clock_r <= candidate[sw_cur_r];
          if (!candidate[sw_cur_r]) begin
            sw_state_r <= SCSM_SW_NEW_LOW;
          end
        end
        default: begin
          system_clock_r <= 1'b0;
          if (!candidate[system_clock_source_r]) begin
            sw_cur_r <= system_clock_source_r;
            sw_state_r <= SCSM_SW_RUN;
          end
        end
      endcase
    end
  end

  assign system_clock_o = system_clock_r;

  // ************************************************************
  // pin copy of the system clock
  // ************************************************************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      system_clock_prev_r <= 1'b0;
      pin_div_cnt_r <= 3'h0;
      system_clock_pin_o <= 1'b0;
    end else begin
      system_clock_prev_r <= system_clock_r;
      if (system_clock_r && !system_clock_prev_r) begin
        pin_div_cnt_r <= pin_div_cnt_r + 3'h1;
      end
      // divide by 1, 2, 4 or 8
      case (system_clock_pin_divide_r)
        2'h0: system_clock_pin_o <= system_clock_r;
        2'h1: system_clock_pin_o <= pin_div_cnt_r[0];
        2'h2: system_clock_pin_o <= pin_div_cnt_r[1];
        default: system_clock_pin_o <= pin_div_cnt_r[2];
      endcase
    end
  end

endmodule

// file: scsm_clock_control_sva.sv
/*
  port checker for the clock control block.
  assumes the 20 MHz control clock and a synchronous active-high reset.
*/
module scsm_clock_control_sva (
  // clock and reset
  input logic mclk_i,
  input logic reset_i,
  // register bus
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  input logic [7:0] reg_rdata_o,
  // outputs
  input logic [2:0] ext_osc_mode_o,
  input logic [2:0] ext_osc_drive_range_o,
  input logic system_clock_o,
  input logic mult_clock_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  a_reset_out_low: assert property ($fell(reset_i) |-> reg_rdata_o == 8'h00 && !system_clock_o && !mult_clock_o)
    else $error("output not low after reset");
  a_valid_off_zero: assert property (reg_rd_i && reg_addr_i == 8'hB1 && ext_osc_mode_o[2:1] != 2'h3
    && $past(ext_osc_mode_o[2:1]) != 2'h3 && $past(ext_osc_mode_o[2:1], 2) != 2'h3 |=> !reg_rdata_o[7])
    else $error("valid flag set outside crystal mode");
  a_mode_follows_wr: assert property (reg_wr_i && reg_addr_i == 8'hB1 |=> ext_osc_mode_o == $past(reg_wdata_i[6:4]))
    else $error("mode output differs from write");
  a_drive_follows_wr: assert property (reg_wr_i && reg_addr_i == 8'hB1
    |=> ext_osc_drive_range_o == $past(reg_wdata_i[2:0]))
    else $error("drive range output differs from write");
  a_xcn_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'hB1 |=> !reg_rdata_o[3])
    else $error("reserved bit read as one");
  a_sel_unused_zero: assert property (reg_rd_i && reg_addr_i == 8'hA9 |=> reg_rdata_o[7:6] == 2'h0
    && reg_rdata_o[3:2] == 2'h0)
    else $error("unused select bits read as one");
  a_disable_drops_ready: assert property (reg_wr_i && reg_addr_i == 8'hAB && !reg_wdata_i[7]
    ##[1:2] reg_rd_i && reg_addr_i == 8'hAB |=> !reg_rdata_o[5])
    else $error("ready still set after disable");
  a_disable_stops_mult: assert property (reg_wr_i && reg_addr_i == 8'hAB && !reg_wdata_i[7]
    |-> ##4 (!mult_clock_o) [*4])
    else $error("multiplier clock runs while disabled");
  a_system_clock_no_glitch: assert property (!$stable(system_clock_o) |=> $stable(system_clock_o))
    else $error("one-cycle pulse on system clock");
endmodule
bind scsm_clock_control scsm_clock_control_sva i_sva (.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .ext_osc_mode_o, .ext_osc_drive_range_o, .system_clock_o, .mult_clock_o);

// file: scsm_osc_src_model.sv
/*
  behavioural oscillator source for the clock control bench.
  assumes nothing of its surroundings beyond a run level.
*/
module scsm_osc_src_model #(
  parameter int HALF_NS = 800
) (
  // control
  input logic run_i,
  // oscillator level
  output logic osc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // free-running square wave, held low while stopped
  initial begin
    osc_o = 1'b0;
    forever begin
      #(HALF_NS);
      osc_o = run_i ? ~osc_o : 1'b0;
    end
  end
endmodule

// file: scsm_clock_control_tb_top.sv
/*
  self-checking bench of the clock control block.
  assumes the oscillator model drives all three clock inputs.
*/
module scsm_clock_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, reset_i, reg_wr_i, reg_rd_i, int_osc_i, ext_osc_i, rtc_osc_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [2:0] internal_divide_select_i, ext_osc_mode_o, ext_osc_drive_range_o;
  logic system_clock_o, system_clock_pin_o, ext_timer_clock_o, mult_clock_o;
  logic [3:0] q;
  wire [3:0] v = {mult_clock_o, ext_timer_clock_o, system_clock_pin_o, system_clock_o};
  logic [7:0] ra[4] = '{8'hA9, 8'hAB, 8'hB1, 8'hAA};
  int n[4];
  int error_cnt = 0;
  int num_checks = 0;
  // ****************
  // design and sources
  // ****************
  scsm_clock_control i_dut (.mclk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .int_osc_i, .ext_osc_i, .rtc_osc_i, .internal_divide_select_i, .ext_osc_mode_o, .ext_osc_drive_range_o,
    .system_clock_o, .system_clock_pin_o, .ext_timer_clock_o, .mult_clock_o);
  scsm_osc_src_model #(.HALF_NS(130)) i_int (.run_i(1'b1), .osc_o(int_osc_i));
  scsm_osc_src_model #(.HALF_NS(800)) i_ext (.run_i(ext_osc_mode_o[2] | ext_osc_mode_o[1]), .osc_o(ext_osc_i));
  scsm_osc_src_model #(.HALF_NS(500)) i_rtc (.run_i(1'b1), .osc_o(rtc_osc_i));
  // control clock
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  // rising-edge counters of the clock outputs
  always @(posedge mclk_i) begin
    q <= v;
    for (int i = 0; i < 4; i++) begin
      if (v[i] === 1'b1 && q[i] === 1'b0) n[i] <= n[i] + 1;
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chkr(input int g, input int lo, input int hi);
    num_checks++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("CHECK FAILED %0t count %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_wdata_i = w;
    reg_wr_i = 1'b1;
    @(negedge mclk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge mclk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge mclk_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input int lo, input int hi);
    int t = 0;
    rd_reg(a);
    while (d[b] !== 1'b1 && t <= hi) begin
      rd_reg(a);
      t += 2;
    end
    chkr(t, lo, hi);
    if (t > hi) wrap_up();
  endtask
  task automatic meas();
    repeat (64) @(negedge mclk_i);
    n = '{default: 0};
    repeat (2048) @(negedge mclk_i);
  endtask
  task automatic sel_chk(input logic [7:0] s, input int lo, input int hi);
    wr_reg(8'hA9, s);
    meas();
    chkr(n[0], lo, hi);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    reset_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    internal_divide_select_i = 3'h7;
    repeat (20) @(negedge mclk_i);
    reset_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_reg(ra[i]);
      chk(d, 8'h00);
    end
    for (int m = 0; m < 8; m++) begin
      wr_reg(8'hB1, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
      rd_reg(8'hB1);
      chk(d, {1'b0, 3'(m), 1'b0, 3'(7 - m)});
      chk({2'b00, ext_osc_mode_o, ext_osc_drive_range_o}, {2'b00, 3'(m), 3'(7 - m)});
    end
    wr_reg(8'hA9, 8'hFB);
    rd_reg(8'hA9);
    chk(d, 8'h33);
    wr_reg(8'hB1, 8'h07);
    wr_reg(8'hB1, 8'h67);
    repeat (20000) @(negedge mclk_i);
    rd_reg(8'hB1);
    chk(d, 8'h67);
    poll(8'hB1, 7, 12700, 12850);
    wr_reg(8'hB1, 8'h27);
    rd_reg(8'hB1);
    chk(d, 8'h27);
    sel_chk(8'h00, 391, 397);
    internal_divide_select_i = 3'h6;
    sel_chk(8'h00, 194, 200);
    sel_chk(8'h01, 62, 66);
    sel_chk(8'h31, 62, 66);
    chkr(n[1], 7, 9);
    sel_chk(8'h03, 100, 105);
    chkr(n[2], 7, 9);
    wr_reg(8'hAB, 8'h00);
    wr_reg(8'hAB, 8'h01);
    wr_reg(8'hAB, 8'h81);
    repeat (110) @(negedge mclk_i);
    wr_reg(8'hAB, 8'hC1);
    rd_reg(8'hAB);
    chk(d, 8'hC1);
    poll(8'hAB, 5, 56, 68);
    sel_chk(8'h02, 252, 260);
    wr_reg(8'hAB, 8'hD1);
    sel_chk(8'h02, 126, 130);
    wr_reg(8'hAB, 8'hC2);
    sel_chk(8'h02, 126, 130);
    sel_chk(8'h00, 194, 200);
    wr_reg(8'hAB, 8'h02);
    rd_reg(8'hAB);
    chk(d, 8'h02);
    meas();
    chkr(n[3], 0, 0);
    wrap_up();
  end
endmodule
